// file: verilog/srsc_defines.vh
// Constants for the serial clock and supervisor core
`ifndef SRSC_DEFINES_VH
`define SRSC_DEFINES_VH
`define SRSC_ADDR_W 6
`define SRSC_CAL_LAST 6'h07
`define SRSC_CTRL_ADDR 6'h08
`define SRSC_CTRL_OUT_BIT 7
`define SRSC_USER_BASE 6'h14
`define SRSC_SLAVE_ADDR 7'h68
`define SRSC_CENT_BIT 6
`define SRSC_XTAL_HZ 17'h08000
`define SRSC_HUND_HZ 17'h00064
`define SRSC_BCD_99 8'h99
`define SRSC_BCD_59 8'h59
`define SRSC_BCD_23 6'h23
`define SRSC_BCD_12 8'h12
`define SRSC_BCD_07 8'h07
`define SRSC_BCD_01 8'h01
`define SRSC_BCD_02 8'h02
`define SRSC_BCD_28 8'h28
`define SRSC_BCD_29 8'h29
`define SRSC_BCD_30 8'h30
`define SRSC_BCD_31 8'h31
`define SRSC_DEB_SAMPLES 8'h10
`define SRSC_SYS_MHZ 20
`define SRSC_POR_US 1000
`define SRSC_POR_CYC (`SRSC_POR_US * `SRSC_SYS_MHZ)
`endif

// file: verilog/srsc_core.v
// Serial clock calendar, battery-backed memory and supervisor core
`timescale 1ns/100ps
`default_nettype none
`include "srsc_defines.vh"

module srsc_core #(
  parameter integer POR_CYCLES = `SRSC_POR_CYC,
  parameter integer DEB_SAMPLES = `SRSC_DEB_SAMPLES
) (
  // Clock and reset
  input wire SYS_CLK,
  input wire RESETN,
  // Serial bus
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE_N,
  // Crystal time base
  input wire XTAL_CLK,
  // Supply sense
  input wire POWER_FAIL_IN,
  output reg BATTERY_SELECT_OUT,
  input wire EARLY_FAIL_SENSE_IN_N,
  output reg EARLY_FAIL_FLAG_OUT_N,
  // External memory select
  input wire HOST_MEMORY_SELECT_IN_N,
  output reg GATED_MEMORY_SELECT_OUT_N,
  // Reset inputs and output
  input wire DEBOUNCED_RESET_IN_A_N,
  input wire DEBOUNCED_RESET_IN_B_N,
  output reg RESET_OUT,
  output reg RESET_OE_N,
  // Alarm and test pin
  output reg ALARM_FREQTEST_OUT,
  output reg ALARM_FREQTEST_OE_N
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_DEV = 5'h02;
  localparam [4:0] ST_REG = 5'h04;
  localparam [4:0] ST_WR = 5'h08;
  localparam [4:0] ST_RD = 5'h10;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  reg [7:0] sync1_ff;
  reg [7:0] sync2_ff;
  reg scl_prev_ff;
  reg sda_prev_ff;
  reg xtal_prev_ff;
  wire scl_s = sync2_ff[0];
  wire sda_s = sync2_ff[1];
  wire xtal_s = sync2_ff[2];
  wire pf_s = sync2_ff[3];
  wire pfi_s = sync2_ff[4];
  wire ex_s = sync2_ff[5];
  wire rsta_s = sync2_ff[6];
  wire rstb_s = sync2_ff[7];
  wire scl_rise = scl_s & ~scl_prev_ff;
  wire scl_fall = ~scl_s & scl_prev_ff;
  wire start_cond = scl_s & scl_prev_ff & ~sda_s & sda_prev_ff;
  wire stop_cond = scl_s & scl_prev_ff & sda_s & ~sda_prev_ff;
  wire xtal_edge = xtal_s & ~xtal_prev_ff;

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      // Idle pin levels, so no false edge or fail after reset
      sync1_ff <= 8'hF3;
      sync2_ff <= 8'hF3;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      xtal_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= {DEBOUNCED_RESET_IN_B_N, DEBOUNCED_RESET_IN_A_N, HOST_MEMORY_SELECT_IN_N,
                   EARLY_FAIL_SENSE_IN_N, POWER_FAIL_IN, XTAL_CLK, SDA_IN, SCL_IN};
      sync2_ff <= sync1_ff;
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
      xtal_prev_ff <= xtal_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // BCD helpers
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function [7:0] month_days;
    input [7:0] mon;
    input [7:0] yr;
    input cent;
    reg leap;
    begin
      leap = (yr[4] ? (yr[1:0] == 2'h2) : (yr[1:0] == 2'h0)) && !(yr == 8'h00 && cent);
      case (mon)
        `SRSC_BCD_02: month_days = leap ? `SRSC_BCD_29 : `SRSC_BCD_28;
        8'h04, 8'h06, 8'h09, 8'h11: month_days = `SRSC_BCD_30;
        default: month_days = `SRSC_BCD_31;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Hundredths tick from crystal edges
  reg [16:0] frac_ff;
  reg tick_ff;
  wire [16:0] frac_sum = frac_ff + `SRSC_HUND_HZ;

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      frac_ff <= 17'h00000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (xtal_edge) begin
        if (frac_sum >= `SRSC_XTAL_HZ) begin
          frac_ff <= frac_sum - `SRSC_XTAL_HZ;
          tick_ff <= 1'b1;
        end else begin
          frac_ff <= frac_sum;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Calendar counters
  reg [7:0] cal_ff [0:7];
  reg [7:0] snap_ff [0:7];
  reg wr_ff;
  reg [5:0] wr_addr_ff;
  reg [7:0] wr_data_ff;
  wire [7:0] c_hs = cal_ff[0];
  wire [7:0] c_sec = cal_ff[1];
  wire [7:0] c_min = cal_ff[2];
  wire [7:0] c_hr = cal_ff[3];
  wire [7:0] c_dow = cal_ff[4];
  wire [7:0] c_date = cal_ff[5];
  wire [7:0] c_mon = cal_ff[6];
  wire [7:0] c_yr = cal_ff[7];
  wire cent = c_hr[`SRSC_CENT_BIT];
  wire cy0 = tick_ff & (c_hs == `SRSC_BCD_99);
  wire cy1 = cy0 & (c_sec == `SRSC_BCD_59);
  wire cy2 = cy1 & (c_min == `SRSC_BCD_59);
  wire cy3 = cy2 & (c_hr[5:0] == `SRSC_BCD_23);
  wire cy4 = cy3 & (c_date == month_days(c_mon, c_yr, cent));
  wire cy5 = cy4 & (c_mon == `SRSC_BCD_12);
  wire cy6 = cy5 & (c_yr == `SRSC_BCD_99);
  wire [7:0] hr_inc = bcd_inc({2'h0, c_hr[5:0]});
  wire wr_cal = wr_ff & (wr_addr_ff <= `SRSC_CAL_LAST);
  integer i;

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (i = 0; i < 8; i = i + 1) begin
        cal_ff[i] <= 8'h00;
      end
      cal_ff[4] <= `SRSC_BCD_01;
      cal_ff[5] <= `SRSC_BCD_01;
      cal_ff[6] <= `SRSC_BCD_01;
    end else if (wr_cal) begin
      cal_ff[wr_addr_ff[2:0]] <= wr_data_ff;
    end else if (tick_ff) begin
      cal_ff[0] <= cy0 ? 8'h00 : bcd_inc(c_hs);
      if (cy0) begin
        cal_ff[1] <= cy1 ? 8'h00 : bcd_inc(c_sec);
      end
      if (cy1) begin
        cal_ff[2] <= cy2 ? 8'h00 : bcd_inc(c_min);
      end
      if (cy2) begin
        cal_ff[3] <= {c_hr[7], cent ^ cy6, cy3 ? 6'h00 : hr_inc[5:0]};
      end
      if (cy3) begin
        // day of week steps at midnight
        cal_ff[4] <= (c_dow == `SRSC_BCD_07) ? `SRSC_BCD_01 : bcd_inc(c_dow);
        cal_ff[5] <= cy4 ? `SRSC_BCD_01 : bcd_inc(c_date);
      end
      if (cy4) begin
        cal_ff[6] <= cy5 ? `SRSC_BCD_01 : bcd_inc(c_mon);
      end
      if (cy5) begin
        cal_ff[7] <= cy6 ? 8'h00 : bcd_inc(c_yr);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // User copy of the clock and memory
  reg [4:0] st_ff;
  reg [5:0] ptr_ff;
  reg [7:0] mem [0:63];
  wire frozen = (st_ff != ST_IDLE) && (ptr_ff <= `SRSC_CAL_LAST);
  wire [7:0] rd_byte = (ptr_ff <= `SRSC_CAL_LAST) ? snap_ff[ptr_ff[2:0]] : mem[ptr_ff];

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (i = 0; i < 8; i = i + 1) begin
        snap_ff[i] <= 8'h00;
      end
    end else if (!frozen) begin
      for (i = 0; i < 8; i = i + 1) begin
        snap_ff[i] <= cal_ff[i];
      end
    end
  end

  // control and user bytes share storage
  always @(posedge SYS_CLK) begin
    if (wr_ff && wr_addr_ff > `SRSC_CAL_LAST) begin
      mem[wr_addr_ff] <= wr_data_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial slave
  reg [3:0] bit_ff;
  reg [7:0] sh_ff;
  reg nack_ff;
  reg [4:0] nxt_st;

  always @* begin
    nxt_st = ST_IDLE;
    case (st_ff)
      ST_DEV: nxt_st = sh_ff[0] ? ST_RD : ST_REG;
      ST_REG: nxt_st = ST_WR;
      ST_WR: nxt_st = ST_WR;
      ST_RD: nxt_st = ST_RD;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_ff <= ST_IDLE;
      ptr_ff <= 6'h00;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      nack_ff <= 1'b0;
      SDA_OE_N <= 1'b1;
      wr_ff <= 1'b0;
      wr_addr_ff <= 6'h00;
      wr_data_ff <= 8'h00;
    end else begin
      wr_ff <= 1'b0;
      if (pf_s) begin
        st_ff <= ST_IDLE;
        ptr_ff <= 6'h00;
        SDA_OE_N <= 1'b1;
      end else if (start_cond) begin
        st_ff <= ST_DEV;
        bit_ff <= 4'h0;
        SDA_OE_N <= 1'b1;
      end else if (stop_cond) begin
        st_ff <= ST_IDLE;
        SDA_OE_N <= 1'b1;
      end else if (st_ff != ST_IDLE) begin
        if (scl_rise) begin
          bit_ff <= bit_ff + 4'h1;
          if (bit_ff < 4'h8) begin
            sh_ff <= {sh_ff[6:0], sda_s};
          end else if (st_ff == ST_WR || st_ff == ST_RD) begin
            ptr_ff <= ptr_ff + 6'h01;
            nack_ff <= sda_s;
          end
        end else if (scl_fall) begin
          if (bit_ff == 4'h8) begin
            if (st_ff == ST_RD) begin
              SDA_OE_N <= 1'b1;
            end else if (st_ff == ST_DEV && sh_ff[7:1] != `SRSC_SLAVE_ADDR) begin
              st_ff <= ST_IDLE;
            end else begin
              SDA_OE_N <= 1'b0;
              if (st_ff == ST_REG) begin
                ptr_ff <= sh_ff[5:0];
              end
              if (st_ff == ST_WR) begin
                wr_ff <= 1'b1;
                wr_addr_ff <= ptr_ff;
                wr_data_ff <= sh_ff;
              end
            end
          end else if (bit_ff == 4'h9) begin
            bit_ff <= 4'h0;
            st_ff <= nxt_st;
            SDA_OE_N <= 1'b1;
            if (nxt_st == ST_RD) begin
              if (st_ff == ST_RD && nack_ff) begin
                st_ff <= ST_IDLE;
              end else begin
                sh_ff <= rd_byte;
                SDA_OE_N <= rd_byte[7];
              end
            end
          end else if (st_ff == ST_RD) begin
            // Shift register already moved the next bit to the top
            SDA_OE_N <= sh_ff[7];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Supervisor: supply, memory gate, resets
  reg [7:0] deb_a_ff;
  reg [7:0] deb_b_ff;
  reg [31:0] por_ff;
  wire deb_a_hit = (deb_a_ff == DEB_SAMPLES[7:0]);
  wire deb_b_hit = (deb_b_ff == DEB_SAMPLES[7:0]);

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      deb_a_ff <= 8'h00;
      deb_b_ff <= 8'h00;
      por_ff <= 32'h00000000;
      SDA_OUT <= 1'b0;
      BATTERY_SELECT_OUT <= 1'b0;
      EARLY_FAIL_FLAG_OUT_N <= 1'b1;
      GATED_MEMORY_SELECT_OUT_N <= 1'b1;
      RESET_OUT <= 1'b0;
      RESET_OE_N <= 1'b0;
      ALARM_FREQTEST_OUT <= 1'b0;
      ALARM_FREQTEST_OE_N <= 1'b1;
    end else begin
      SDA_OUT <= 1'b0;
      if (rsta_s) begin
        deb_a_ff <= 8'h00;
      end else if (xtal_edge && !deb_a_hit) begin
        deb_a_ff <= deb_a_ff + 8'h01;
      end
      if (rstb_s) begin
        deb_b_ff <= 8'h00;
      end else if (xtal_edge && !deb_b_hit) begin
        deb_b_ff <= deb_b_ff + 8'h01;
      end
      if (pf_s) begin
        por_ff <= 32'h00000000;
      end else if (por_ff < POR_CYCLES) begin
        por_ff <= por_ff + 32'h00000001;
      end
      // battery takes over on supply loss
      BATTERY_SELECT_OUT <= pf_s;
      EARLY_FAIL_FLAG_OUT_N <= pfi_s;
      GATED_MEMORY_SELECT_OUT_N <= pf_s | ex_s;
      RESET_OUT <= 1'b0;
      RESET_OE_N <= ~(deb_a_hit | deb_b_hit | pf_s | (por_ff < POR_CYCLES));
      ALARM_FREQTEST_OUT <= 1'b0;
      if (wr_ff && wr_addr_ff == `SRSC_CTRL_ADDR) begin
        ALARM_FREQTEST_OE_N <= wr_data_ff[`SRSC_CTRL_OUT_BIT];
      end
    end
  end

endmodule // srsc_core

`default_nettype wire

// file: tb/srsc_monitor.sv
// Port checker for the serial clock supervisor core
`timescale 1ns/100ps
`default_nettype none
module srsc_monitor #(
  parameter integer POR_CYCLES = 20,
  parameter integer DEB_SAMPLES = 16
) (
  // Clock, reset, inputs
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic SCL_IN,
  input wire logic XTAL_CLK,
  input wire logic POWER_FAIL_IN,
  input wire logic HOST_MEMORY_SELECT_IN_N,
  input wire logic DEBOUNCED_RESET_IN_A_N,
  input wire logic DEBOUNCED_RESET_IN_B_N,
  // Outputs
  input wire logic SDA_OE_N,
  input wire logic BATTERY_SELECT_OUT,
  input wire logic GATED_MEMORY_SELECT_OUT_N,
  input wire logic RESET_OUT,
  input wire logic RESET_OE_N,
  input wire logic ALARM_FREQTEST_OUT
);
  logic xt_ff;
  logic [7:0] lo_ff;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////
  // Crystal rises seen while a reset input is low
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      xt_ff <= 1'h0;
      lo_ff <= 8'h00;
    end else begin
      xt_ff <= XTAL_CLK;
      if (DEBOUNCED_RESET_IN_A_N && DEBOUNCED_RESET_IN_B_N)
        lo_ff <= 8'h00;
      else if (XTAL_CLK && !xt_ff && lo_ff != 8'hFF)
        lo_ff <= lo_ff + 8'h01;
    end
  end
  ////////////////////////////////////////
  sequence s_pf; POWER_FAIL_IN [*5]; endsequence
  sequence s_ok; (!POWER_FAIL_IN && $stable(HOST_MEMORY_SELECT_IN_N)) [*5]; endsequence
  property p_pf_gate; s_pf |-> GATED_MEMORY_SELECT_OUT_N; endproperty
  property p_ok_gate; s_ok |-> GATED_MEMORY_SELECT_OUT_N == HOST_MEMORY_SELECT_IN_N; endproperty
  property p_pf_batt; s_pf |-> BATTERY_SELECT_OUT; endproperty
  property p_pf_rst; s_pf |-> !RESET_OE_N; endproperty
  property p_pf_bus; s_pf |-> SDA_OE_N; endproperty
  property p_rst_src;
    $fell(RESET_OE_N) |-> POWER_FAIL_IN || !DEBOUNCED_RESET_IN_A_N || !DEBOUNCED_RESET_IN_B_N;
  endproperty
  property p_deb; $fell(RESET_OE_N) && !POWER_FAIL_IN |-> lo_ff >= DEB_SAMPLES - 1; endproperty
  property p_drain_rst; !RESET_OUT; endproperty
  property p_drain_alm; !ALARM_FREQTEST_OUT; endproperty
  property p_ack_low; $fell(SDA_OE_N) |-> !SCL_IN && !POWER_FAIL_IN; endproperty
  a_pf_gate: assert property (p_pf_gate) else $error("select not gated");
  a_ok_gate: assert property (p_ok_gate) else $error("select not passed");
  a_pf_batt: assert property (p_pf_batt) else $error("no battery switch");
  a_pf_rst: assert property (p_pf_rst) else $error("no reset on fail");
  a_pf_bus: assert property (p_pf_bus) else $error("bus driven on fail");
  a_rst_src: assert property (p_rst_src) else $error("reset without cause");
  a_deb: assert property (p_deb) else $error("reset input too short");
  a_drain_rst: assert property (p_drain_rst) else $error("reset driven high");
  a_drain_alm: assert property (p_drain_alm) else $error("alarm driven high");
  a_ack_low: assert property (p_ack_low) else $error("data pulled at clock high");
endmodule // srsc_monitor
bind srsc_core srsc_monitor #(.POR_CYCLES(POR_CYCLES), .DEB_SAMPLES(DEB_SAMPLES)) mon (.*);
`default_nettype wire

// file: tb/srsc_host_model.sv
// Bus master model for the serial port
`timescale 1ns/100ps
`default_nettype none
module srsc_host_model (
  // Clock and wire level
  input wire logic sys_clk,
  input wire logic sda_line,
  // Master drive, high is released
  output logic scl_out,
  output logic sda_drv,
  // Result of each byte
  output logic res_stb,
  output logic [7:0] res_val
);
  initial begin
    scl_out = 1'h1;
    sda_drv = 1'h1;
    res_stb = 1'h0;
    res_val = 8'h00;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One clock pulse, data may change mid-high
  task automatic clk(input logic b0, input logic b1, input logic fall, output logic r);
    sda_drv <= b0;
    hw(6);
    scl_out <= 1'h1;
    hw(4);
    r = sda_line;
    sda_drv <= b1;
    hw(4);
    if (fall) begin
      scl_out <= 1'h0;
      hw(2);
    end
  endtask
  task automatic emit(input logic [7:0] v);
    res_val <= v;
    res_stb <= 1'h1;
    hw(1);
    res_stb <= 1'h0;
  endtask
  task automatic start;
    logic r;
    clk(1'h1, 1'h0, 1'h1, r);
  endtask
  task automatic stop;
    logic r;
    clk(1'h0, 1'h1, 1'h0, r);
  endtask
  task automatic put(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk(d[i], d[i], 1'h1, r);
    clk(1'h1, 1'h1, 1'h1, r);
    emit({7'h00, r});
  endtask
  task automatic get(input logic nack);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--) clk(1'h1, 1'h1, 1'h1, d[i]);
    clk(nack, nack, 1'h1, r);
    emit(d);
  endtask
endmodule // srsc_host_model
`default_nettype wire

// file: tb/srsc_core_bench.sv
// Self-checking bench for the serial clock supervisor core
`timescale 1ns/100ps
`default_nettype none
`include "srsc_defines.vh"
module srsc_core_bench;
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic xtal_clk = 1'h0;
  logic power_fail = 1'h0;
  logic early_n = 1'h1;
  logic host_sel_n = 1'h1;
  logic rst_a_n = 1'h1;
  logic rst_b_n = 1'h1;
  logic [31:0] seed = 32'h98A1890E;
  logic [7:0] exp_q[$];
  logic [7:0] ram [0:3];
  logic [7:0] tc [0:2][0:5] = '{'{8'h23, 8'h28, 8'h02, 8'h24, 8'h29, 8'h02},
    '{8'h63, 8'h28, 8'h02, 8'h00, 8'h01, 8'h03}, '{8'h23, 8'h30, 8'h04, 8'h25, 8'h01, 8'h05}};
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  wire scl, m_sda, sda_oe_n, sda_out, res_stb, gated_n, rst_oe_n, alarm_oe_n, batt;
  wire early_flag_n;
  wire [7:0] res_val;
  wire sda_line = m_sda & (sda_oe_n | sda_out);
  always #25 sys_clk = ~sys_clk;
  initial begin
    #13;
    forever #200 xtal_clk = ~xtal_clk;
  end
  srsc_core #(.POR_CYCLES(20), .DEB_SAMPLES(4)) uut (
    .SYS_CLK(sys_clk), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out),
    .SDA_OE_N(sda_oe_n), .XTAL_CLK(xtal_clk), .POWER_FAIL_IN(power_fail),
    .BATTERY_SELECT_OUT(batt), .EARLY_FAIL_SENSE_IN_N(early_n),
    .EARLY_FAIL_FLAG_OUT_N(early_flag_n),
    .HOST_MEMORY_SELECT_IN_N(host_sel_n), .GATED_MEMORY_SELECT_OUT_N(gated_n),
    .DEBOUNCED_RESET_IN_A_N(rst_a_n), .DEBOUNCED_RESET_IN_B_N(rst_b_n), .RESET_OUT(),
    .RESET_OE_N(rst_oe_n), .ALARM_FREQTEST_OUT(), .ALARM_FREQTEST_OE_N(alarm_oe_n));
  srsc_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl_out(scl),
    .sda_drv(m_sda), .res_stb(res_stb), .res_val(res_val));
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic cy(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic put(input logic [7:0] d, input logic nack);
    exp_q.push_back({7'h00, nack});
    host.put(d);
  endtask
  task automatic rd(input logic [7:0] e, input logic nack);
    exp_q.push_back(e);
    host.get(nack);
  endtask
  task automatic setp(input logic [5:0] p, input logic go_read);
    host.start();
    put({`SRSC_SLAVE_ADDR, 1'h0}, 1'h0);
    put({2'h0, p}, 1'h0);
    if (go_read) begin
      host.start();
      put({`SRSC_SLAVE_ADDR, 1'h1}, 1'h0);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // Result watcher and cycle ceiling
  always @(posedge sys_clk) begin
    cyc++;
    if (res_stb === 1'h1)
      chk("bus byte", exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, res_val);
    if (cyc == 60000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    cy(4);
    resetn <= 1'h1;
    cy(30);
    chk("reset out", 8'h01, {7'h00, rst_oe_n});
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      ram[i] = seed[7:0];
    end
    early_n <= seed[8];
    setp(`SRSC_USER_BASE, 1'h0);
    for (int i = 0; i < 4; i++) put(ram[i], 1'h0);
    host.stop();
    chk("early flag", {7'h00, seed[8]}, {7'h00, early_flag_n});
    setp(`SRSC_USER_BASE, 1'h0);
    host.stop();
    host.start();
    put({`SRSC_SLAVE_ADDR, 1'h1}, 1'h0);
    for (int i = 0; i < 4; i++) rd(ram[i], i == 3);
    host.stop();
    host.start();
    put(8'hA0, 1'h1);
    host.stop();
    for (int v = 0; v < 2; v++) begin
      setp(`SRSC_CTRL_ADDR, 1'h0);
      put({v[0], 7'h00}, 1'h0);
      host.stop();
      cy(4);
      chk("alarm pin", {7'h00, v[0]}, {7'h00, alarm_oe_n});
    end
    for (int k = 0; k < 3; k++) begin
      setp(6'h01, 1'h0);
      put(`SRSC_BCD_59, 1'h0);
      put(`SRSC_BCD_59, 1'h0);
      put(tc[k][0], 1'h0);
      put(`SRSC_BCD_07, 1'h0);
      for (int j = 1; j < 4; j++) put(tc[k][j], 1'h0);
      host.stop();
      setp(6'h00, 1'h0);
      put(`SRSC_BCD_99, 1'h0);
      host.stop();
      cy(3000);
      setp(6'h01, 1'h1);
      rd(8'h00, 1'h0);
      rd(8'h00, 1'h0);
      rd(tc[k][0] & 8'h40, 1'h0);
      rd(`SRSC_BCD_01, 1'h0);
      rd(tc[k][4], 1'h0);
      rd(tc[k][5], 1'h0);
      rd(tc[k][3], 1'h1);
      host.stop();
    end
    host_sel_n <= 1'h0;
    cy(8);
    chk("memory select", 8'h00, {7'h00, gated_n});
    power_fail <= 1'h1;
    cy(8);
    chk("memory select", 8'h01, {7'h00, gated_n});
    chk("battery", 8'h01, {7'h00, batt});
    chk("reset out", 8'h00, {7'h00, rst_oe_n});
    host.start();
    put({`SRSC_SLAVE_ADDR, 1'h0}, 1'h1);
    host.stop();
    power_fail <= 1'h0;
    host_sel_n <= 1'h1;
    cy(40);
    for (int i = 0; i < 2; i++) begin
      for (int n = 16; n <= 64; n += 48) begin
        {rst_b_n, rst_a_n} <= i ? 2'h1 : 2'h2;
        cy(n);
        chk("reset out", {7'h00, n == 16}, {7'h00, rst_oe_n});
        {rst_b_n, rst_a_n} <= 2'h3;
        cy(40);
      end
    end
    cy(4);
    tally_and_finish();
  end
endmodule // srsc_core_bench
`default_nettype wire
